// ### smsc_top.sv
// Standby control registers, module clock enables, sleep entry and input sampling
`timescale 1ns/1ps
module smsc_top (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sleepExec,
  input  wire smsc_pkg::smsc_async_t asyncIn,
  output smsc_pkg::smsc_async_t    sampledIn,
  output logic      [3:0]          serialClkEn,
  output logic      [7:0]          moduleClkEn,
  output logic                     traceClkEn,
  output logic                     traceResetN,
  output logic                     pinHold,
  output logic                     pinFloat,
  output logic                     softStandby,
  output logic                     deepStandby
);

  logic [smsc_pkg::NREG-2:0][7:0] regs_r;
  smsc_pkg::smsc_async_t          meta_r;
  smsc_pkg::smsc_async_t          sampled_r;
  smsc_pkg::smsc_state_t          state_r;
  smsc_pkg::smsc_state_t          state_nxt;
  logic                           wrPhase_r;
  logic [31:0]                    wrAddr_r;
  logic [31:0]                    hrdata_r;
  logic                           hreadyout_r;
  logic [3:0]                     serialClkEn_r;
  logic [7:0]                     moduleClkEn_r;
  logic                           traceClkEn_r;
  logic                           traceResetN_r;
  logic                           pinHold_r;
  logic                           pinFloat_r;
  logic                           softStandby_r;
  logic                           deepStandby_r;

  // Bus decode
  wire        accept     = hsel & hready & (htrans == smsc_pkg::HTRANS_NONSEQ);
  wire        acceptWr   = accept & hwrite;
  wire        acceptRd   = accept & ~hwrite;
  wire [29:0] rdIndex    = haddr[31:2];
  wire [29:0] wrIndex    = wrAddr_r[31:2];
  wire [7:0]  statValue  = {6'h00, state_r == smsc_pkg::SMSC_DEEP,
                            state_r == smsc_pkg::SMSC_SOFT};
  wire [7:0]  rdValue    = (haddr == smsc_pkg::OFF_ONE)  ? regs_r[smsc_pkg::IDX_ONE]  :
                           (haddr == smsc_pkg::OFF_SER)  ? regs_r[smsc_pkg::IDX_SER]  :
                           (haddr == smsc_pkg::OFF_FOUR) ? regs_r[smsc_pkg::IDX_FOUR] :
                           (haddr == smsc_pkg::OFF_FIVE) ? regs_r[smsc_pkg::IDX_FIVE] :
                           (haddr == smsc_pkg::OFF_SIX)  ? regs_r[smsc_pkg::IDX_SIX]  :
                           (haddr == smsc_pkg::OFF_STAT) ? statValue : 8'h00;
  wire        rdMapped   = (rdIndex <= 30'(smsc_pkg::IDX_STAT));

  // Named control bits
  wire standbyEn  = regs_r[smsc_pkg::IDX_ONE][smsc_pkg::BIT_STANDBY_EN];
  wire depthSoft  = regs_r[smsc_pkg::IDX_SIX][smsc_pkg::BIT_DEPTH];
  wire floatSel   = regs_r[smsc_pkg::IDX_SIX][smsc_pkg::BIT_PIN_FLOAT];
  wire running    = (state_r == smsc_pkg::SMSC_RUN);
  wire wakeEvent  = sampled_r.powerOnResetIn | sampled_r.manualResetIn |
                    sampled_r.nmiIn | (|sampled_r.externalIrqIn);

  // Address phase capture; every write gets one wait state so a following read sees it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPhase_r   <= 1'b0;
      wrAddr_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
    end else begin
      wrPhase_r   <= acceptWr;
      hreadyout_r <= ~acceptWr;
      if (acceptWr) begin
        wrAddr_r <= haddr;
      end
      if (acceptRd) begin
        hrdata_r <= rdMapped ? {24'h00_0000, rdValue} : 32'h0000_0000;
      end
    end
  end

  // Stored registers, masked writes keep read-only bits at their reset value
  genvar gi;
  generate
    for (gi = 0; gi < smsc_pkg::NREG - 1; gi++) begin : g_reg
      wire hit = wrPhase_r & (wrIndex == 30'(gi));
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          regs_r[gi] <= smsc_pkg::RSTV[gi];
        end else if (hit) begin
          regs_r[gi] <= (regs_r[gi] & ~smsc_pkg::WMASK[gi]) |
                        (hwdata[7:0] & smsc_pkg::WMASK[gi]);
        end
      end
    end
  endgenerate

  // Two-stage sampling of asynchronous inputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r    <= '0;
      sampled_r <= '0;
    end else begin
      meta_r    <= asyncIn;
      sampled_r <= meta_r;
    end
  end

  // Sleep entry and wake
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      smsc_pkg::SMSC_RUN: begin
        if (sleepExec && standbyEn) begin
          state_nxt = depthSoft ? smsc_pkg::SMSC_SOFT : smsc_pkg::SMSC_DEEP;
        end
      end
      smsc_pkg::SMSC_SOFT,
      smsc_pkg::SMSC_DEEP: begin
        if (wakeEvent) begin
          state_nxt = smsc_pkg::SMSC_RUN;
        end
      end
      default: state_nxt = smsc_pkg::SMSC_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= smsc_pkg::SMSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clock enables change only at an edge, so gated clocks see whole pulses
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serialClkEn_r <= 4'h0;
      moduleClkEn_r <= 8'h00;
      traceClkEn_r  <= 1'b0;
      traceResetN_r <= 1'b0;
      pinHold_r     <= 1'b0;
      pinFloat_r    <= 1'b0;
      softStandby_r <= 1'b0;
      deepStandby_r <= 1'b0;
    end else begin
      serialClkEn_r <= ~regs_r[smsc_pkg::IDX_SER][5:2] & {4{running}};
      moduleClkEn_r <= ~regs_r[smsc_pkg::IDX_FOUR] & {8{running}};
      traceClkEn_r  <= ~regs_r[smsc_pkg::IDX_FIVE][smsc_pkg::BIT_TRACE_STOP] & running;
      traceResetN_r <= regs_r[smsc_pkg::IDX_SIX][smsc_pkg::BIT_TRACE_RST];
      pinHold_r     <= (state_nxt == smsc_pkg::SMSC_SOFT) & ~floatSel;
      pinFloat_r    <= (state_nxt == smsc_pkg::SMSC_DEEP) |
                       ((state_nxt == smsc_pkg::SMSC_SOFT) & floatSel);
      softStandby_r <= (state_nxt == smsc_pkg::SMSC_SOFT);
      deepStandby_r <= (state_nxt == smsc_pkg::SMSC_DEEP);
    end
  end

  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = smsc_pkg::HRESP_OKAY;
  assign sampledIn   = sampled_r;
  assign serialClkEn = serialClkEn_r;
  assign moduleClkEn = moduleClkEn_r;
  assign traceClkEn  = traceClkEn_r;
  assign traceResetN = traceResetN_r;
  assign pinHold     = pinHold_r;
  assign pinFloat    = pinFloat_r;
  assign softStandby = softStandby_r;
  assign deepStandby = deepStandby_r;

  // Checks
  serial_stop_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    regs_r[smsc_pkg::IDX_SER][smsc_pkg::BIT_SER_STOP] |=> !serialClkEn_r[0])
    else $error("serial unit clock runs while stopped");

  ser_reserved_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    regs_r[smsc_pkg::IDX_SER][1:0] == 2'b11)
    else $error("serial stop reserved bits not one");

  four_readonly_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrPhase_r && wrIndex == 30'(smsc_pkg::IDX_FOUR)
    |=> regs_r[smsc_pkg::IDX_FOUR] == ({3'b111, 2'b00, 3'b111} & $past(hwdata[7:0]) | 8'h18))
    else $error("control four write mask wrong");

  six_write_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrPhase_r && wrIndex == 30'(smsc_pkg::IDX_SIX)
    |=> regs_r[smsc_pkg::IDX_SIX] == ($past(hwdata[7:0]) & 8'hc2))
    else $error("control six writable bits wrong");

  six_reserved_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (regs_r[smsc_pkg::IDX_SIX] & 8'h3d) == 8'h00)
    else $error("control six reserved bits not zero");

  trace_reset_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrPhase_r && wrIndex == 30'(smsc_pkg::IDX_SIX) && !hwdata[7]
    |=> ##1 !traceResetN_r)
    else $error("trace unit not held in reset");

  pin_float_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    state_r == smsc_pkg::SMSC_SOFT && $stable(state_r) && $stable(floatSel)
    |-> pinFloat_r == floatSel && pinHold_r == !floatSel)
    else $error("standby pin state wrong");

  sleep_depth_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    running && sleepExec && standbyEn
    |=> state_r == ($past(depthSoft) ? smsc_pkg::SMSC_SOFT : smsc_pkg::SMSC_DEEP))
    else $error("wrong standby depth entered");

  input_sample_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $stable(reset_n) ##1 $stable(reset_n) |-> sampled_r == $past(asyncIn, 2))
    else $error("input sampling latency wrong");

  write_wait_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptWr |=> !hreadyout_r ##1 hreadyout_r)
    else $error("write wait state missing");

  serial_run_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    running && !regs_r[smsc_pkg::IDX_SER][smsc_pkg::BIT_SER_STOP] |=> serialClkEn_r[0])
    else $error("serial unit clock stopped while enabled");

  ser_write_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrPhase_r && wrIndex == 30'(smsc_pkg::IDX_SER)
    |=> regs_r[smsc_pkg::IDX_SER] == (($past(hwdata[7:0]) & 8'h3c) | 8'h03))
    else $error("serial stop write mask wrong");

  ser_read_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptRd && haddr == smsc_pkg::OFF_SER |=> hrdata_r[1:0] == 2'b11)
    else $error("serial stop reserved bits read wrong");

  four_fixed_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    regs_r[smsc_pkg::IDX_FOUR][4:3] == 2'b11)
    else $error("control four read-only bits changed");

  four_read_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptRd && haddr == smsc_pkg::OFF_FOUR
    |=> hrdata_r == {24'h00_0000, $past(regs_r[smsc_pkg::IDX_FOUR])})
    else $error("control four read data wrong");

  four_enable_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    moduleClkEn_r[4:3] == 2'b00)
    else $error("unused module clock enable set");

  six_read_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptRd && haddr == smsc_pkg::OFF_SIX
    |=> (hrdata_r & 32'h0000_003d) == 32'h0000_0000)
    else $error("control six reserved bits read nonzero");

  trace_release_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    regs_r[smsc_pkg::IDX_SIX][smsc_pkg::BIT_TRACE_RST] |=> traceResetN_r)
    else $error("trace unit not released");

  trace_clock_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    running
    |=> traceClkEn_r == !$past(regs_r[smsc_pkg::IDX_FIVE][smsc_pkg::BIT_TRACE_STOP]))
    else $error("trace clock enable wrong");

  module_stop_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    running |=> moduleClkEn_r == ~$past(regs_r[smsc_pkg::IDX_FOUR]))
    else $error("module clock enables wrong");

  standby_gate_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    !running |=> moduleClkEn_r == 8'h00 && serialClkEn_r == 4'h0 && !traceClkEn_r)
    else $error("clock enable active in standby");

  soft_pins_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    softStandby_r |-> pinHold_r == !$past(floatSel) && pinFloat_r == $past(floatSel))
    else $error("software standby pin state wrong");

  deep_pins_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    deepStandby_r |-> pinFloat_r && !pinHold_r)
    else $error("deep standby pins not floating");

  run_pins_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    !softStandby_r && !deepStandby_r |-> !pinFloat_r && !pinHold_r)
    else $error("pins held or floating while running");

  sleep_refused_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    running && sleepExec && !standbyEn |=> state_r == smsc_pkg::SMSC_RUN)
    else $error("sleep entered with standby disabled");

  standby_stay_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    !running && !wakeEvent |=> state_r == $past(state_r))
    else $error("standby left without wake event");

  wake_exit_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    !running && wakeEvent |=> state_r == smsc_pkg::SMSC_RUN)
    else $error("wake event ignored in standby");

  read_nowait_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptRd |=> hreadyout_r)
    else $error("read inserted a wait state");

  read_upper_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    hrdata_r[31:8] == 24'h00_0000)
    else $error("read data upper bits nonzero");

  unmapped_read_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    acceptRd && !rdMapped |=> hrdata_r == 32'h0000_0000)
    else $error("unmapped read returned data");

  input_stage_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $stable(reset_n) |-> meta_r == $past(asyncIn))
    else $error("first sampling stage wrong");

  write_ignore_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    wrPhase_r && wrIndex > 30'(smsc_pkg::IDX_SIX) |=> $stable(regs_r))
    else $error("unmapped write changed a register");

endmodule : smsc_top

// ### smsc_pkg.sv
// Constants, register map and carrier types of the standby and module stop control block
package smsc_pkg;

  localparam int NREG     = 6;
  localparam int IDX_ONE  = 0;
  localparam int IDX_SER  = 1;
  localparam int IDX_FOUR = 2;
  localparam int IDX_FIVE = 3;
  localparam int IDX_SIX  = 4;
  localparam int IDX_STAT = 5;

  localparam logic [31:0] OFF_ONE  = 32'h0000_0000;
  localparam logic [31:0] OFF_SER  = 32'h0000_0004;
  localparam logic [31:0] OFF_FOUR = 32'h0000_0008;
  localparam logic [31:0] OFF_FIVE = 32'h0000_000c;
  localparam logic [31:0] OFF_SIX  = 32'h0000_0010;
  localparam logic [31:0] OFF_STAT = 32'h0000_0014;

  // Writable bits and reset values, index order stat, six, five, four, ser, one
  localparam logic [NREG-1:0][7:0] WMASK = {8'h00, 8'hc2, 8'h02, 8'he7, 8'h3c, 8'h80};
  localparam logic [NREG-1:0][7:0] RSTV  = {8'h00, 8'h00, 8'h02, 8'hff, 8'h3f, 8'h00};

  localparam int BIT_STANDBY_EN = 7;
  localparam int BIT_SER_STOP   = 2;
  localparam int BIT_TRACE_STOP = 1;
  localparam int BIT_TRACE_RST  = 7;
  localparam int BIT_PIN_FLOAT  = 6;
  localparam int BIT_DEPTH      = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {SMSC_RUN, SMSC_SOFT, SMSC_DEEP} smsc_state_t;

  typedef struct packed {
    logic       powerOnResetIn;
    logic       manualResetIn;
    logic       nmiIn;
    logic       busRequestIn;
    logic [7:0] externalIrqIn;
  } smsc_async_t;

endpackage : smsc_pkg

// ### tb_smsc_top.sv
// Self-checking testbench of the standby and module stop control block
`timescale 1ns/1ps
module tb_smsc_top;
  logic                  clock = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  hsel = 1'b0;
  logic [31:0]           haddr = 32'h0;
  logic [1:0]            htrans = 2'b00;
  logic                  hwrite = 1'b0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           hwdata = 32'h0;
  logic                  sleepExec = 1'b0;
  smsc_pkg::smsc_async_t asyncIn = '0;
  smsc_pkg::smsc_async_t sampledIn;
  logic [31:0]           hrdata;
  logic                  hreadyout, hresp, traceClkEn, traceResetN;
  logic                  pinHold, pinFloat, softStandby, deepStandby;
  logic [3:0]            serialClkEn;
  logic [7:0]            moduleClkEn;
  logic [31:0]           rv;
  int                    miscompares = 0;
  int                    nTests = 0;
  int                    cycles = 0;
  always #5 clock = ~clock;
  smsc_top dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleepExec(sleepExec),
    .asyncIn(asyncIn), .sampledIn(sampledIn), .serialClkEn(serialClkEn),
    .moduleClkEn(moduleClkEn), .traceClkEn(traceClkEn), .traceResetN(traceResetN),
    .pinHold(pinHold), .pinFloat(pinFloat), .softStandby(softStandby),
    .deepStandby(deepStandby));
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= smsc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, smsc_pkg::HRESP_OKAY});
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask : wr
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rv);
    chk(rv, exp);
  endtask : rdchk
  task automatic t_reset;
    rdchk(smsc_pkg::OFF_ONE, 32'h00);
    rdchk(smsc_pkg::OFF_SER, 32'h3f);
    rdchk(smsc_pkg::OFF_FOUR, 32'hff);
    rdchk(smsc_pkg::OFF_FIVE, 32'h02);
    rdchk(smsc_pkg::OFF_SIX, 32'h00);
    chk({28'h0, serialClkEn}, 32'h0);
    chk({24'h0, moduleClkEn}, 32'h0);
    chk({31'h0, traceResetN}, 32'h0);
    chk({31'h0, traceClkEn}, 32'h0);
    $display("reset values done");
  endtask : t_reset
  task automatic t_masks;
    wr(smsc_pkg::OFF_SER, 32'h03);
    rdchk(smsc_pkg::OFF_SER, 32'h03);
    chk({28'h0, serialClkEn}, 32'hf);
    wr(smsc_pkg::OFF_SER, 32'hfb);
    @(negedge clock);
    chk({28'h0, serialClkEn}, 32'h1);
    wr(smsc_pkg::OFF_FOUR, 32'h0);
    rdchk(smsc_pkg::OFF_FOUR, 32'h18);
    chk({24'h0, moduleClkEn}, 32'he7);
    wr(smsc_pkg::OFF_FIVE, 32'h0);
    wr(smsc_pkg::OFF_SIX, 32'hc2);
    rdchk(smsc_pkg::OFF_SIX, 32'hc2);
    chk({31'h0, traceResetN}, 32'h1);
    chk({31'h0, traceClkEn}, 32'h1);
    wr(smsc_pkg::OFF_SIX, 32'h0);
    @(negedge clock);
    chk({31'h0, traceResetN}, 32'h0);
    wr(32'h40, 32'hff);
    rdchk(32'h40, 32'h0);
    $display("register masks done");
  endtask : t_masks
  task automatic sleep_case(input logic [7:0] six, input logic [3:0] exp);
    wr(smsc_pkg::OFF_SIX, {24'h0, six});
    @(posedge clock);
    sleepExec <= 1'b1;
    @(posedge clock);
    sleepExec <= 1'b0;
    @(negedge clock);
    chk({28'h0, softStandby, deepStandby, pinHold, pinFloat}, {28'h0, exp});
    @(negedge clock);
    chk({23'h0, traceClkEn, moduleClkEn}, (exp == 4'h0) ? 32'h1e7 : 32'h0);
    @(posedge clock);
    asyncIn.externalIrqIn <= 8'h01;
    repeat (4) @(posedge clock);
    asyncIn.externalIrqIn <= 8'h00;
    repeat (4) @(posedge clock);
    chk({28'h0, softStandby, deepStandby, pinHold, pinFloat}, 32'h0);
  endtask : sleep_case
  task automatic t_sleep;
    sleep_case(8'h02, 4'h0);
    wr(smsc_pkg::OFF_ONE, 32'h80);
    sleep_case(8'h02, 4'ha);
    sleep_case(8'h42, 4'h9);
    sleep_case(8'h00, 4'h5);
    chk({24'h0, moduleClkEn}, 32'he7);
    $display("sleep entry done");
  endtask : t_sleep
  task automatic t_sample;
    @(posedge clock);
    asyncIn <= '{1'b1, 1'b0, 1'b1, 1'b1, 8'h5a};
    @(posedge clock);
    @(negedge clock);
    chk({20'h0, sampledIn}, 32'h0);
    @(negedge clock);
    chk({20'h0, sampledIn}, 32'hb5a);
    @(posedge clock);
    asyncIn <= '0;
    $display("input sampling done");
  endtask : t_sample
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_masks();
    t_sleep();
    t_sample();
    close_out();
  end
endmodule : tb_smsc_top
